// ### src/transceiver_irq_mask_logic.sv
// Interrupt mask register, status flags, request pin and doze control
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Request pin asserts while any status flag is set with its mask bit one.
// - Host reading status clears pending flags; host must do that read.
// - Masked source still sets its flag but does not drive the pin.
// - Mask bit 15 gates attention; it is set out of reset.
// - Mask bit 12 gates packet RAM address error.
// - Mask bit 11 gates packet RAM arbiter busy error.
// - Mask bit 10 gates stream data error.
// - Mask bit 9 gates oscillator PLL unlock.
// - Bit 8 deep doze: leave only on attention, timer clocks stopped.
// - Bit 8 zero: leave doze on comparator two match or attention.
// - Mask bit 4 gates doze timer.
// - Mask bit 3 gates fourth event timer compare.
// - Mask bit 2 gates third event timer compare.
// - Mask bit 1 gates second event timer compare.
// - Mask bit 0 gates first event timer compare.
// - Requests masked in another control register share the same pin.
module transceiver_irq_mask_logic
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [5:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   input  wire logic        attention_event,
   input  wire logic        ram_addr_error_event,
   input  wire logic        arb_busy_error_event,
   input  wire logic        stream_data_error_event,
   input  wire logic        pll_unlock_event,
   input  wire logic        doze_timer_event,
   input  wire logic        compare_one_event,
   input  wire logic        compare_two_event,
   input  wire logic        compare_three_event,
   input  wire logic        compare_four_event,
   input  wire logic        ext_irq_request,
   input  wire logic        doze_request,
   input  wire logic        attention_in,
   input  wire logic        second_timer_comparator,
   output logic             irq_request,
   output logic             dozing,
   output logic             doze_exit,
   output logic             timer_clock_run
);

   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [1:0]
   {
      ST_AWAKE = 2'b01,
      ST_DOZE  = 2'b10
   } doze_state_t;

   doze_state_t state_reg;
   doze_state_t state_next;
   logic [15:0] mask_reg;
   logic [15:0] mask_next;
   logic [15:0] flags_reg;
   logic [15:0] flags_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        irq_reg;
   logic        irq_next;
   logic        exit_reg;
   logic        exit_next;
   logic        run_reg;
   logic        run_next;
   logic        dozing_reg;
   logic        dozing_next;
   logic [15:0] src_vec;
   logic        deep_doze;
   logic        wake;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
      hit = (a == target);
   endfunction

   // ****************************************
   // Source vector in mask bit order
   // ****************************************
   always_comb
   begin
      src_vec = 16'h0000;
      src_vec[irq_mask_pkg::ATTN_BIT]       = attention_event;
      src_vec[irq_mask_pkg::RAM_ADDR_BIT]   = ram_addr_error_event;
      src_vec[irq_mask_pkg::ARB_BUSY_BIT]   = arb_busy_error_event;
      src_vec[irq_mask_pkg::STRM_DATA_BIT]  = stream_data_error_event;
      src_vec[irq_mask_pkg::PLL_UNLOCK_BIT] = pll_unlock_event;
      src_vec[irq_mask_pkg::DOZE_TMR_BIT]   = doze_timer_event;
      src_vec[irq_mask_pkg::CMP_FOUR_BIT]   = compare_four_event;
      src_vec[irq_mask_pkg::CMP_THREE_BIT]  = compare_three_event;
      src_vec[irq_mask_pkg::CMP_TWO_BIT]    = compare_two_event;
      src_vec[irq_mask_pkg::CMP_ONE_BIT]    = compare_one_event;
   end

   // ****************************************
   // Registers, flags and request pin
   // ****************************************
   always_comb
   begin
      mask_next  = mask_reg;
      flags_next = flags_reg;
      rdata_next = 16'h0000;
      // Reserved bits never store, so they read as zero
      if (reg_wr && hit(reg_addr, irq_mask_pkg::MASK_ADDR))
      begin
         mask_next = reg_wdata & irq_mask_pkg::MASK_WRITABLE;
      end
      if (reg_rd && hit(reg_addr, irq_mask_pkg::MASK_ADDR))
      begin
         rdata_next = mask_reg;
      end
      if (reg_rd && hit(reg_addr, irq_mask_pkg::STATUS_ADDR))
      begin
         rdata_next = flags_reg;
         flags_next = 16'h0000;
      end
      // flags set regardless of mask; set beats a same-cycle clear
      flags_next = flags_next | src_vec;
      // masked flags drive request, per bit
      // shared with requests from other control register
      irq_next = (|(flags_reg & mask_reg & irq_mask_pkg::SOURCE_BITS)) | ext_irq_request;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mask_reg  <= irq_mask_pkg::MASK_RESET;
         flags_reg <= irq_mask_pkg::STATUS_RESET;
         rdata_reg <= 16'h0000;
         irq_reg   <= 1'b0;
      end
      else
      begin
         mask_reg  <= mask_next;
         flags_reg <= flags_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
      end
   end

   // ****************************************
   // Doze control
   // ****************************************
   assign deep_doze = mask_reg[irq_mask_pkg::DEEP_DOZE_BIT];
   // wake sources depend on deep doze
   assign wake = attention_in || (!deep_doze && second_timer_comparator);

   always_comb
   begin
      state_next = state_reg;
      exit_next  = 1'b0;
      case (state_reg)
         ST_AWAKE:
         begin
            if (doze_request)
            begin
               state_next = ST_DOZE;
            end
         end
         ST_DOZE:
         begin
            if (wake)
            begin
               state_next = ST_AWAKE;
               exit_next  = 1'b1;
            end
         end
         default:
         begin
            state_next = ST_AWAKE;
         end
      endcase
      // timer and prescaler clocks stop in deep doze
      run_next = !((state_next == ST_DOZE) && deep_doze);
      // Own flop so the pin is not a decode of the state
      dozing_next = (state_next == ST_DOZE);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_AWAKE;
         exit_reg  <= 1'b0;
         run_reg   <= 1'b1;
         dozing_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         exit_reg  <= exit_next;
         run_reg   <= run_next;
         dozing_reg <= dozing_next;
      end
   end

   assign reg_rdata       = rdata_reg;
   assign irq_request     = irq_reg;
   assign dozing          = dozing_reg;
   assign doze_exit       = exit_reg;
   assign timer_clock_run = run_reg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_irq_follows;
      ##1 irq_request == ($past(|(flags_reg & mask_reg & irq_mask_pkg::SOURCE_BITS))
                          || $past(ext_irq_request));
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("request pin wrong");

   property p_read_clears;
      (reg_rd && reg_addr == irq_mask_pkg::STATUS_ADDR && src_vec == 16'h0000)
         |=> flags_reg == 16'h0000 && reg_rdata == $past(flags_reg);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

   property p_set_unmasked;
      (src_vec != 16'h0000) |=> ((flags_reg & $past(src_vec)) == $past(src_vec));
   endproperty
   a_set_unmasked: assert property (p_set_unmasked) else $error("flag not set");

   property p_masked_quiet;
      (mask_reg == 16'h0000 && !ext_irq_request) |=> !irq_request;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("masked source drove pin");

   property p_reserved_zero;
      (mask_reg & ~irq_mask_pkg::MASK_WRITABLE) == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

   property p_attn_gate;
      (flags_reg[irq_mask_pkg::ATTN_BIT] && mask_reg[irq_mask_pkg::ATTN_BIT]) |=> irq_request;
   endproperty
   a_attn_gate: assert property (p_attn_gate) else $error("attention not on pin");

   property p_cmp_gate;
      ((flags_reg[irq_mask_pkg::CMP_ONE_BIT] && mask_reg[irq_mask_pkg::CMP_ONE_BIT])
       || (flags_reg[irq_mask_pkg::CMP_FOUR_BIT] && mask_reg[irq_mask_pkg::CMP_FOUR_BIT]))
         |=> irq_request;
   endproperty
   a_cmp_gate: assert property (p_cmp_gate) else $error("compare not on pin");

   property p_deep_stays;
      (dozing && deep_doze && !attention_in) |=> dozing && !timer_clock_run;
   endproperty
   a_deep_stays: assert property (p_deep_stays) else $error("deep doze left early");

   property p_tc_wake;
      (dozing && !deep_doze && second_timer_comparator) |=> !dozing && doze_exit;
   endproperty
   a_tc_wake: assert property (p_tc_wake) else $error("comparator did not wake");

   property p_mask_write;
      (reg_wr && reg_addr == irq_mask_pkg::MASK_ADDR)
         |=> mask_reg == ($past(reg_wdata) & irq_mask_pkg::MASK_WRITABLE);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   c_irq_raise: cover property (!irq_request ##1 irq_request);
   c_status_clear: cover property (reg_rd && reg_addr == irq_mask_pkg::STATUS_ADDR
                                   && flags_reg != 16'h0000);
   c_deep_wake: cover property (dozing && deep_doze && attention_in);
   c_tc_exit: cover property (dozing && !deep_doze && second_timer_comparator);

endmodule // transceiver_irq_mask_logic

`default_nettype wire

// ### src/irq_mask_pkg.sv
// Constants for the interrupt mask and status logic
`default_nettype none
package irq_mask_pkg;
   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [5:0]  MASK_ADDR       = 6'h05;
   localparam logic [5:0]  STATUS_ADDR     = 6'h24;
   // ****************************************
   // Mask register fields
   // ****************************************
   localparam int          ATTN_BIT        = 15;
   localparam int          RAM_ADDR_BIT    = 12;
   localparam int          ARB_BUSY_BIT    = 11;
   localparam int          STRM_DATA_BIT   = 10;
   localparam int          PLL_UNLOCK_BIT  = 9;
   localparam int          DEEP_DOZE_BIT   = 8;
   localparam int          DOZE_TMR_BIT    = 4;
   localparam int          CMP_FOUR_BIT    = 3;
   localparam int          CMP_THREE_BIT   = 2;
   localparam int          CMP_TWO_BIT     = 1;
   localparam int          CMP_ONE_BIT     = 0;
   // Writable bits; reserved 14-13 and 7-5 stay at zero
   localparam logic [15:0] MASK_WRITABLE   = 16'h9F1F;
   // Bits that gate a status source onto the request pin
   localparam logic [15:0] SOURCE_BITS     = 16'h9E1F;
   localparam logic [15:0] MASK_RESET      = 16'h8000;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
endpackage : irq_mask_pkg
`default_nettype wire

// ### src/placeholder_unused_never.sv
// Intentionally empty design companion
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### verif/host_model.sv
// Host model driving the block's decoded register port
`timescale 1ns/1ps
`default_nettype none
module host_model
(
   input  wire logic        clk,
   input  wire logic [15:0] reg_rdata,
   output logic      [5:0]  reg_addr,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [15:0] reg_wdata
);
   initial
   begin
      reg_addr  = 6'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = 16'h0000;
   end

   task automatic reg_read(input logic [5:0] a, output logic [15:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      d      = reg_rdata;
   endtask

   task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Stale data would hide a write taken late
      reg_wdata = ~d;
   endtask

   task automatic mask_write(input logic [15:0] d);
      reg_write(irq_mask_pkg::MASK_ADDR, d & irq_mask_pkg::MASK_WRITABLE);
   endtask

   task automatic status_read(output logic [15:0] d);
      reg_read(irq_mask_pkg::STATUS_ADDR, d);
   endtask
endmodule // host_model
`default_nettype wire

// ### verif/tb_transceiver_irq_mask_logic.sv
// Self-checking bench for the interrupt mask logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_transceiver_irq_mask_logic;
   logic        clk, srst, reg_wr, reg_rd, ext_irq_request;
   logic        irq_request, dozing, doze_exit, timer_clock_run;
   logic [5:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd;
   logic [12:0] stim;
   int          n_fail = 0, cmp_count = 0, cyc = 0;
   // Status positions in the order of stim[9:0]
   int          bitpos[10] = '{15, 12, 11, 10, 9, 4, 0, 1, 2, 3};

   host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

   transceiver_irq_mask_logic dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .attention_event(stim[0]), .ram_addr_error_event(stim[1]),
      .arb_busy_error_event(stim[2]), .stream_data_error_event(stim[3]),
      .pll_unlock_event(stim[4]), .doze_timer_event(stim[5]),
      .compare_one_event(stim[6]), .compare_two_event(stim[7]),
      .compare_three_event(stim[8]), .compare_four_event(stim[9]),
      .ext_irq_request(ext_irq_request), .doze_request(stim[10]),
      .attention_in(stim[11]), .second_timer_comparator(stim[12]),
      .irq_request(irq_request), .dozing(dozing), .doze_exit(doze_exit),
      .timer_clock_run(timer_clock_run));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic conclude();
      $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One-cycle strobe on the chosen inputs
   task automatic pulse(input logic [12:0] v);
      @(negedge clk);
      stim = v;
      @(negedge clk);
      stim = 13'h0000;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         conclude();
      end
   end

   initial
   begin
      stim            = 13'h0000;
      ext_irq_request = 1'b0;
      srst            = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      host_u.reg_read(irq_mask_pkg::MASK_ADDR, rd);
      `CHK(rd, 16'h8000)
      host_u.reg_read(6'h3F, rd);
      `CHK(rd, 16'h0000)
      host_u.reg_write(irq_mask_pkg::MASK_ADDR, 16'hFFFF);
      host_u.reg_read(irq_mask_pkg::MASK_ADDR, rd);
      `CHK(rd, 16'h9F1F)
      for (int i = 0; i < 10; i++)
      begin
         host_u.mask_write(16'h0001 << bitpos[i]);
         pulse(13'h0001 << i);
         repeat (2) @(negedge clk);
         `CHK(irq_request, 1'b1)
         host_u.status_read(rd);
         `CHK(rd, 16'h0001 << bitpos[i])
         repeat (2) @(negedge clk);
         `CHK(irq_request, 1'b0)
         host_u.mask_write(~(16'h0001 << bitpos[i]));
         pulse(13'h0001 << i);
         repeat (2) @(negedge clk);
         `CHK(irq_request, 1'b0)
         host_u.status_read(rd);
         `CHK(rd, 16'h0001 << bitpos[i])
      end
      host_u.mask_write(16'h0000);
      @(negedge clk);
      ext_irq_request = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(irq_request, 1'b1)
      ext_irq_request = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(irq_request, 1'b0)
      pulse(13'h0400);
      `CHK({dozing, timer_clock_run}, 2'b11)
      pulse(13'h1000);
      `CHK({dozing, doze_exit}, 2'b01)
      @(negedge clk);
      `CHK(doze_exit, 1'b0)
      host_u.mask_write(16'h0100);
      pulse(13'h0400);
      `CHK({dozing, timer_clock_run}, 2'b10)
      pulse(13'h1000);
      @(negedge clk);
      `CHK({dozing, timer_clock_run}, 2'b10)
      pulse(13'h0800);
      `CHK({dozing, doze_exit, timer_clock_run}, 3'b011)
      host_u.mask_write(16'h8000);
      pulse(13'h0400);
      pulse(13'h0800);
      `CHK({dozing, doze_exit, timer_clock_run}, 3'b011)
      pulse(13'h0001);
      repeat (2) @(negedge clk);
      `CHK(irq_request, 1'b1)
      // Second reset with a request pending
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      `CHK({irq_request, dozing, doze_exit, timer_clock_run}, 4'b0001)
      host_u.status_read(rd);
      `CHK(rd, 16'h0000)
      host_u.reg_read(irq_mask_pkg::MASK_ADDR, rd);
      `CHK(rd, 16'h8000)
      conclude();
   end
endmodule // tb_transceiver_irq_mask_logic
`default_nettype wire
